// file: rtl/bgpio_defs.vh
// register map, field positions and reset values of the two-bank pin port
// assumes: included by bare name from the rtl files of this block
`ifndef BGPIO_DEFS_VH
`define BGPIO_DEFS_VH

// byte offsets on the register bus
`define BGPIO_OFS_FIRST_BANK 8'h00
`define BGPIO_OFS_SECOND_BANK 8'h04
`define BGPIO_OFS_WIDTH 8

// field positions inside a bank word: mode 31:24, direction 23:16, special 15:8, data 7:0
`define BGPIO_MODE_LSB 24
`define BGPIO_DIR_LSB 16
`define BGPIO_SF_LSB 8
`define BGPIO_DATA_LSB 0
`define BGPIO_BANK_PINS 8

// pin roles in the second bank
`define BGPIO_LED_OUTPUT_BIT 6
`define BGPIO_BUTTON_INPUT_BIT 5

// reset values: second bank pin 6 output driving high, everything else input
`define BGPIO_FIRST_RST 32'h0000_0000
`define BGPIO_SECOND_DIR_RST 8'h40
`define BGPIO_SECOND_DATA_RST 8'h40

// ahb-lite codes
`define BGPIO_HTRANS_NONSEQ 2'h2
`define BGPIO_HSIZE_WORD 3'h2

`endif

// file: rtl/bgpio_sync2.v
// two-stage synchroniser for a vector of pin levels
// assumes: inputs are asynchronous to i_clk
`timescale 1ns/1ps
`default_nettype none

module bgpio_sync2 #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire i_clk,
    input wire i_sys_rst,
    // levels
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // first stage is read only by the second
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_r <= {WIDTH{1'b1}};
            sync_r <= {WIDTH{1'b1}};
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule

`default_nettype wire

// file: rtl/bgpio_top.v
// two-bank, sixteen pin general-purpose port with an ahb-lite register slave
// assumes: one 125 MHz clock, pins are external and asynchronous
//
// Function
// R1: sixteen pins, two registers, eight each
// R2: mode, direction, data; special only second bank
// R3: all zero input; direction one output; the code drives the pin only when direction is one with mode and special clear
// R4: read gives pin level; write sets output
// R5: software does read-modify-write of words
// R6: software leaves reserved pins untouched
// R7: second bank pin 6 drives LED high
// R8: second bank pin 5 reads button, low pressed
// R9: pin levels pass two flip-flops first
`timescale 1ns/1ps
`default_nettype none
`include "bgpio_defs.vh"

module bgpio_top #(
    parameter PINS = 16
) (
    // clock and reset
    input wire i_clk,
    input wire i_sys_rst,
    // ahb-lite slave
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output reg [31:0] o_hrdata,
    output reg o_hreadyout,
    output reg o_hresp,
    // pins: input, output, output enable
    input wire [PINS-1:0] i_pin,
    output reg [PINS-1:0] o_pin,
    output reg [PINS-1:0] o_pin_oe
);

    localparam N = `BGPIO_BANK_PINS;

    // ------------------------------------------------------------
    // reset words
    // ------------------------------------------------------------
    // kept as parameters so fields slice like a register word
    localparam [31:0] FIRST_RST_W = `BGPIO_FIRST_RST;
    localparam [N-1:0] SECOND_DIR_RST = `BGPIO_SECOND_DIR_RST;
    localparam [N-1:0] SECOND_DATA_RST = `BGPIO_SECOND_DATA_RST;
    // led pin leaves reset already driven high, so it never flickers off
    localparam [PINS-1:0] PIN_RST = {SECOND_DATA_RST, {N{1'b0}}};
    localparam [PINS-1:0] OE_RST = {SECOND_DIR_RST, {N{1'b0}}};

    // ------------------------------------------------------------
    // bank configuration
    // ------------------------------------------------------------
    reg [N-1:0] a_mode_r;
    reg [N-1:0] a_dir_r;
    reg [N-1:0] a_data_r;
    reg [N-1:0] c_mode_r;
    reg [N-1:0] c_dir_r;
    reg [N-1:0] c_sf_r;
    reg [N-1:0] c_data_r;
    wire [PINS-1:0] pin_sync;

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    bgpio_sync2 #(.WIDTH(PINS)) u_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async(i_pin),
        .o_sync(pin_sync)
    ); // [R9] [R8]

    // pin drives only in plain output mode
    function out_mode;
        input mode;
        input dir;
        input sf;
        begin
            out_mode = ~mode & dir & ~sf; // [R3]
        end
    endfunction

    // ------------------------------------------------------------
    // register words as read
    // ------------------------------------------------------------
    // data field is the synchronised pin level, output or not
    reg [31:0] word_a;
    reg [31:0] word_c;
    always @* begin
        word_a = 32'h0000_0000;
        word_a[`BGPIO_MODE_LSB +: N] = a_mode_r;
        word_a[`BGPIO_DIR_LSB +: N] = a_dir_r;
        word_a[`BGPIO_DATA_LSB +: N] = pin_sync[N-1:0]; // [R4]
        word_c = 32'h0000_0000;
        word_c[`BGPIO_MODE_LSB +: N] = c_mode_r;
        word_c[`BGPIO_DIR_LSB +: N] = c_dir_r;
        word_c[`BGPIO_SF_LSB +: N] = c_sf_r; // [R2]
        word_c[`BGPIO_DATA_LSB +: N] = pin_sync[PINS-1:N]; // [R4] [R8]
    end

    // unmapped offsets read as zero and take no write
    function [31:0] sel_word;
        input [`BGPIO_OFS_WIDTH-1:0] ofs;
        input [31:0] wa;
        input [31:0] wc;
        begin
            case (ofs)
                `BGPIO_OFS_FIRST_BANK: sel_word = wa; // [R1]
                `BGPIO_OFS_SECOND_BANK: sel_word = wc; // [R1]
                default: sel_word = 32'h0000_0000;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------
    reg dp_act_r, dp_wr_r;
    reg [`BGPIO_OFS_WIDTH-1:0] dp_addr_r;
    wire ap_go = i_hsel & i_hready & (i_htrans == `BGPIO_HTRANS_NONSEQ);

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dp_act_r <= 1'b0;
            dp_wr_r <= 1'b0;
            dp_addr_r <= {`BGPIO_OFS_WIDTH{1'b0}};
        end else begin
            dp_act_r <= ap_go;
            dp_wr_r <= ap_go & i_hwrite;
            if (ap_go) begin
                dp_addr_r <= i_haddr[`BGPIO_OFS_WIDTH-1:0];
            end
        end
    end

    wire wr_a = dp_act_r & dp_wr_r & (dp_addr_r == `BGPIO_OFS_FIRST_BANK);
    wire wr_c = dp_act_r & dp_wr_r & (dp_addr_r == `BGPIO_OFS_SECOND_BANK);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // whole word written; software merges other pins itself
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            a_mode_r <= FIRST_RST_W[`BGPIO_MODE_LSB +: N];
            a_dir_r <= FIRST_RST_W[`BGPIO_DIR_LSB +: N];
            a_data_r <= FIRST_RST_W[`BGPIO_DATA_LSB +: N];
            c_mode_r <= {N{1'b0}};
            c_dir_r <= SECOND_DIR_RST; // [R7]
            c_sf_r <= {N{1'b0}};
            c_data_r <= SECOND_DATA_RST; // [R7]
        end else begin
            if (wr_a) begin // [R1] [R5]
                a_mode_r <= i_hwdata[`BGPIO_MODE_LSB +: N];
                a_dir_r <= i_hwdata[`BGPIO_DIR_LSB +: N];
                a_data_r <= i_hwdata[`BGPIO_DATA_LSB +: N]; // [R4]
            end
            if (wr_c) begin // [R1] [R2]
                c_mode_r <= i_hwdata[`BGPIO_MODE_LSB +: N];
                c_dir_r <= i_hwdata[`BGPIO_DIR_LSB +: N];
                c_sf_r <= i_hwdata[`BGPIO_SF_LSB +: N];
                c_data_r <= i_hwdata[`BGPIO_DATA_LSB +: N]; // [R4]
            end
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    wire [PINS-1:0] oe_nxt;
    wire [PINS-1:0] pin_nxt;
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_pin
            // first bank has no special bit, so it counts as clear
            assign oe_nxt[g] = out_mode(a_mode_r[g], a_dir_r[g], 1'b0); // [R2] [R3]
            assign oe_nxt[g+N] = out_mode(c_mode_r[g], c_dir_r[g], c_sf_r[g]); // [R3]
            assign pin_nxt[g] = a_data_r[g];
            assign pin_nxt[g+N] = c_data_r[g]; // [R4] [R7]
        end
    endgenerate

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pin <= PIN_RST; // [R7]
            o_pin_oe <= OE_RST; // [R7]
        end else begin
            o_pin <= pin_nxt;
            o_pin_oe <= oe_nxt;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // loaded at the address phase edge, so it stands through the data phase;
    // refreshed at the data phase edge while no new read is taken
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_hrdata <= 32'h0000_0000;
        end else if (ap_go & ~i_hwrite) begin
            o_hrdata <= sel_word(i_haddr[`BGPIO_OFS_WIDTH-1:0], word_a, word_c); // [R1] [R4]
        end else if (dp_act_r & ~dp_wr_r) begin
            o_hrdata <= sel_word(dp_addr_r, word_a, word_c); // [R4]
        end
    end

    // ------------------------------------------------------------
    // bus response
    // ------------------------------------------------------------
    // one data phase per access, never a wait state or an error
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// file: tb/bgpio_monitor.sv
// checker for bus answers and pin outputs of the two-bank port
// assumes: bound to bgpio_top, hready looped back from hreadyout
`timescale 1ns/1ps
`default_nettype none
module bgpio_monitor (
    input wire i_clk, i_sys_rst, i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp,
    input wire [1:0] i_htrans,
    input wire [31:0] i_haddr, i_hwdata, o_hrdata,
    input wire [15:0] i_pin, o_pin, o_pin_oe
);
    // ----------------------------------------
    // helpers and properties
    // ----------------------------------------
    wire take = i_hsel & i_hready & (i_htrans == 2'h2);
    wire rd0 = take & !i_hwrite & (i_haddr[7:0] == 8'h00);
    wire rd4 = take & !i_hwrite & (i_haddr[7:0] == 8'h04);
    reg wr_r;
    reg [7:0] a_r;
    reg [1:0] age_r;
    function [7:0] oe_f(input [31:0] w);
        oe_f = ~w[31:24] & w[23:16] & ~w[15:8];
    endfunction
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_r <= 1'b0;
            a_r <= 8'h00;
            age_r <= 2'h0;
        end else begin
            wr_r <= take & i_hwrite;
            a_r <= i_haddr[7:0];
            // synchronisers restart at ones, so level reads are judged later
            age_r <= age_r + {1'b0, age_r != 2'h3};
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    okay_ready_a: assert property (o_hreadyout && !o_hresp)
        else $error("bus answer not ready and okay");
    reset_led_a: assert property ($fell(i_sys_rst) |-> o_pin == 16'h4000 && o_pin_oe == 16'h4000)
        else $error("led pin not driven high after reset");
    oe_second_a: assert property (wr_r && a_r == 8'h04 |-> ##2 o_pin_oe[15:8] == oe_f($past(i_hwdata, 2)))
        else $error("second bank enables wrong");
    oe_first_a: assert property (wr_r && a_r == 8'h00 |->
        ##2 o_pin_oe[7:0] == oe_f($past(i_hwdata, 2) & 32'hffff_00ff))
        else $error("first bank enables wrong");
    drive_level_a: assert property (wr_r && a_r == 8'h04 |-> ##2 o_pin[15:8] == $past(i_hwdata[7:0], 2))
        else $error("second bank drive level wrong");
    read_second_a: assert property ((age_r == 2'h3 && $stable(i_pin)) [*3] ##0 rd4 |=>
        o_hrdata[7:0] == $past(i_pin[15:8]))
        else $error("second bank level read wrong");
    read_first_a: assert property ((age_r == 2'h3 && $stable(i_pin)) [*3] ##0 rd0 |=>
        o_hrdata[15:0] == {8'h00, $past(i_pin[7:0])})
        else $error("first bank read wrong");
    unmapped_zero_a: assert property (take && !i_hwrite && i_haddr[7:3] != 5'h00 |=>
        o_hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule
`default_nettype wire

// file: tb/bgpio_board.sv
// board side: red indicator on pin 14, push button on pin 13
// assumes: i_float gives the level of pins nobody drives
`timescale 1ns/1ps
`default_nettype none
module bgpio_board (
    // from the port
    input wire [15:0] i_pin_out,
    input wire [15:0] i_pin_oe,
    // board controls
    input wire i_pressed,
    input wire [15:0] i_float,
    // to the port and the bench
    output wire [15:0] o_pin,
    output wire o_led_lit
);
    // button pulls its pin high when released, low when pressed
    wire [15:0] idle = (16'h2000 & {16{~i_pressed}}) | (i_float & 16'hdfff);
    assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & idle);
    assign o_led_lit = i_pin_oe[14] & i_pin_out[14];
endmodule
`default_nettype wire

// file: tb/bgpio_top_bench.sv
// bench for the two-bank port: bus tasks, board model, checks
// assumes: bgpio_top, bgpio_board and bgpio_monitor compiled first
`timescale 1ns/1ps
`default_nettype none
module bgpio_top_bench;
    reg i_clk = 1'b0, i_sys_rst = 1'b1, i_hsel = 1'b0, i_hwrite = 1'b0, pressed = 1'b0, oe;
    reg [1:0] i_htrans = 2'h0;
    reg [31:0] i_haddr = 32'h0000_0000, i_hwdata = 32'h0000_0000, r, w;
    reg [19:0] tbl = 20'h0_6c40;
    reg [3:0] m;
    wire [31:0] o_hrdata;
    wire o_hreadyout, o_hresp, led;
    wire [15:0] i_pin, o_pin, o_pin_oe;
    integer error_cnt = 0, total_checks = 0, i;
    bgpio_top i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
        .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
        .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe));
    bgpio_board i_board (.i_pin_out(o_pin), .i_pin_oe(o_pin_oe), .i_pressed(pressed),
        .i_float(16'h0000), .o_pin(i_pin), .o_led_lit(led));
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task xfer(input [31:0] a, input wr, input [31:0] d);
        begin
            i_hsel <= 1'b1;
            i_htrans <= 2'h2;
            i_haddr <= a;
            i_hwrite <= wr;
            @(posedge i_clk);
            while (o_hreadyout !== 1'b1) @(posedge i_clk);
            i_htrans <= 2'h0;
            i_hwdata <= d;
            @(posedge i_clk);
            while (o_hreadyout !== 1'b1) @(posedge i_clk);
            r = o_hrdata;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // only one pin's four bits change, the rest is written back as read
    task rmw(input integer b, input [3:0] v);
        begin
            xfer(32'h0000_0004, 1'b0, 32'h0000_0000);
            w = r;
            {w[24+b], w[16+b], w[8+b], w[b]} = v;
            xfer(32'h0000_0004, 1'b1, w);
            repeat (4) @(posedge i_clk);
        end
    endtask
    task test_done;
        begin
            if (error_cnt == 0 && total_checks > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask
    // ----------------------------------------
    // clock, watchdog and tests
    // ----------------------------------------
    initial forever #4 i_clk = ~i_clk;
    initial begin
        #20000;
        error_cnt = error_cnt + 1;
        test_done;
    end
    initial begin
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        xfer(32'h0000_0000, 1'b0, 32'h0000_0000);
        chk(r, 32'h0000_0000);
        xfer(32'h0000_0000, 1'b1, r);
        xfer(32'h0000_0004, 1'b0, 32'h0000_0000);
        chk(r, 32'h0040_0060);
        pressed <= 1'b1;
        repeat (4) @(posedge i_clk);
        xfer(32'h0000_0004, 1'b0, 32'h0000_0000);
        chk(r, 32'h0040_0040);
        pressed <= 1'b0;
        // button pin through input, output, mode set, special set, back to input
        for (i = 0; i < 5; i = i + 1) begin
            m = tbl[i*4 +: 4];
            rmw(5, m);
            oe = ~m[3] & m[2] & ~m[1];
            chk({31'h0000_0000, o_pin_oe[13]}, {31'h0000_0000, oe});
            xfer(32'h0000_0004, 1'b0, 32'h0000_0000);
            chk(r, {w[31:6], ~oe, w[4:0]});
        end
        rmw(6, 4'b0100);
        chk({31'h0000_0000, led}, 32'h0000_0000);
        rmw(6, 4'b0101);
        chk({31'h0000_0000, led}, 32'h0000_0001);
        xfer(32'h0000_0008, 1'b1, 32'hffff_ffff);
        xfer(32'h0000_0008, 1'b0, 32'h0000_0000);
        chk(r, 32'h0000_0000);
        // button pin keeps the released level that the write-backs carried into its data bit
        chk({o_pin, o_pin_oe}, 32'h6000_4000);
        test_done;
    end
endmodule
bind bgpio_top bgpio_monitor i_mon (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_hwrite(i_hwrite),
    .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_htrans(i_htrans), .i_haddr(i_haddr),
    .i_hwdata(i_hwdata), .o_hrdata(o_hrdata), .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe));
`default_nettype wire
